// ### src/lscm_ctrl.sv
// Low-speed oscillator and operating mode control
`include "lscm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module lscm_ctrl (
  input wire logic REF_CLK, // 250 MHz clock
  input wire logic RST, // Power-on reset, active high
  input wire logic [1:0] OSC_CFG, // Oscillator configuration option
  input wire logic [1:0] WDT_SRC, // Watchdog clock source option
  input wire logic LOW_SPEED_INTERNAL_RC_OPT_EN, // Low RC enabled by option
  input wire logic LP_WR, // Write strobe for low-power bit
  input wire logic LP_WDATA, // Low-power bit write data
  input wire logic SEL_WR, // Write strobe for clock-select bit
  input wire logic SEL_WDATA, // Clock-select bit write data
  input wire logic HALT, // Halt instruction executed, pulse
  input wire logic WAKE, // Wake-up event, pulse
  input wire logic WDT_TIMEOUT, // Watchdog overflow, pulse
  input wire logic CLR_WDT, // Clear watchdog instruction, pulse
  input wire logic HI_TICK, // High speed source tick
  input wire logic LO_TICK, // Crystal tick
  output logic SLOW_OSC_LOW_POWER_BIT, // Crystal low-power mode
  output logic SYSTEM_CLOCK_SELECT_BIT, // Clock-select bit readback
  output logic [1:0] MODE, // Operating mode
  output logic HIGH_SPEED_INTERNAL_RC_EN, // High RC running
  output logic LOW_SPEED_CRYSTAL_OSC_EN, // Crystal running
  output logic LOW_SPEED_INTERNAL_RC_EN, // Low RC running
  output logic POWER_DOWN_FLAG, // Power-down status
  output logic WATCHDOG_TIMEOUT_FLAG, // Time-out status
  output logic WDT_CLEAR, // Watchdog clear, pulse
  output logic WDT_RUN, // Watchdog may count
  output logic CORE_STALL, // Core held at halt
  output logic SYS_TICK_Q // Registered system tick
);
  lscm_pkg::lscm_state_type st_r;
  lscm_pkg::lscm_state_type st_nxt;
  logic tick_r;
  logic sys_tick;
  logic lxt_cfg;
  logic halted;
  lscm_mux_if mux_if ();

  lscm_clk_switch u_switch (
    .clk(REF_CLK),
    .rst(RST),
    .hi_tick(HI_TICK),
    .lo_tick(LO_TICK),
    .ctl(mux_if.mux),
    .sys_tick(sys_tick)
  );

  // ************************************
  // Mode and flag logic
  // ************************************
  // crystal tied to RC config
  assign lxt_cfg = (OSC_CFG == `LSCM_OSC_HIGH_SPEED_INTERNAL_RC_LXT);

  // ************************************
  // Decode helpers
  // ************************************
  function automatic logic is_halted(input lscm_pkg::lscm_mode_type m);
    is_halted = (m == lscm_pkg::LSCM_IDLE) || (m == lscm_pkg::LSCM_SLEEP);
  endfunction

  // Select bit only counts when the crystal is configured
  function automatic lscm_pkg::lscm_mode_type run_mode(input logic cfg_ok, input logic sel);
    if (cfg_ok && sel) begin
      run_mode = lscm_pkg::LSCM_SLOW;
    end else begin
      run_mode = lscm_pkg::LSCM_NORMAL;
    end
  endfunction

  // Idle keeps the crystal alive for the timers, Sleep leaves only the low RC running when its option is set
  function automatic lscm_pkg::lscm_mode_type halt_mode(input logic cfg_ok);
    if (cfg_ok) begin
      halt_mode = lscm_pkg::LSCM_IDLE;
    end else begin
      halt_mode = lscm_pkg::LSCM_SLEEP;
    end
  endfunction

  // System-clocked watchdog loses its clock once halted
  function automatic logic wdt_runs(input logic [1:0] src, input lscm_pkg::lscm_mode_type m);
    wdt_runs = !((src == `LSCM_WDTSRC_SYS) && is_halted(m));
  endfunction

  assign halted = is_halted(st_r.mode);

  // ************************************
  // Next-state logic
  // ************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.wdt_clr = 1'b0;
    if (LP_WR) begin
      st_nxt.lp = LP_WDATA;
    end
    if (SEL_WR) begin
      st_nxt.sel = SEL_WDATA;
    end
    st_nxt.lxt_en = lxt_cfg;
    st_nxt.low_speed_internal_rc_en = LOW_SPEED_INTERNAL_RC_OPT_EN;
    if (CLR_WDT) begin
      st_nxt.wdt_clr = 1'b1;
      st_nxt.power_down_flag = 1'b0;
    end
    unique case (st_r.mode)
      lscm_pkg::LSCM_NORMAL, lscm_pkg::LSCM_SLOW: begin
        // select ignored outside RC plus crystal
        st_nxt.mode = run_mode(lxt_cfg, st_nxt.sel);
        if (HALT) begin
          st_nxt.mode = halt_mode(lxt_cfg);
          st_nxt.power_down_flag = 1'b1;
          st_nxt.tof = 1'b0;
          st_nxt.wdt_clr = 1'b1;
        end
      end
      lscm_pkg::LSCM_IDLE, lscm_pkg::LSCM_SLEEP: begin
        // Watchdog overflow wakes as well as the wake event
        if (WAKE || WDT_TIMEOUT) begin
          st_nxt.mode = run_mode(lxt_cfg, st_nxt.sel);
        end
      end
    endcase
    // Time-out set wins over the halt clear
    if (WDT_TIMEOUT) begin
      st_nxt.tof = 1'b1;
    end
    st_nxt.high_speed_internal_rc_en = (st_nxt.mode == lscm_pkg::LSCM_NORMAL);
    st_nxt.wdt_run = wdt_runs(WDT_SRC, st_nxt.mode);
    st_nxt.stall = is_halted(st_nxt.mode);
  end

  // ************************************
  // State register
  // ************************************

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_r.lp <= `LSCM_LP_RESET;
      st_r.sel <= `LSCM_SEL_RESET;
      st_r.mode <= lscm_pkg::LSCM_NORMAL;
      st_r.power_down_flag <= 1'b0;
      st_r.tof <= 1'b0;
      st_r.wdt_clr <= 1'b0;
      st_r.wdt_run <= 1'b1;
      st_r.high_speed_internal_rc_en <= 1'b1;
      st_r.lxt_en <= 1'b0;
      st_r.low_speed_internal_rc_en <= 1'b0;
      st_r.stall <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tick_r <= sys_tick;
    end
  end

  assign mux_if.want_lo = (st_r.mode == lscm_pkg::LSCM_SLOW);
  assign mux_if.gate = halted;

  assign SLOW_OSC_LOW_POWER_BIT = st_r.lp;
  assign SYSTEM_CLOCK_SELECT_BIT = st_r.sel;
  assign MODE = st_r.mode;
  assign HIGH_SPEED_INTERNAL_RC_EN = st_r.high_speed_internal_rc_en;
  assign LOW_SPEED_CRYSTAL_OSC_EN = st_r.lxt_en;
  assign LOW_SPEED_INTERNAL_RC_EN = st_r.low_speed_internal_rc_en;
  assign POWER_DOWN_FLAG = st_r.power_down_flag;
  assign WATCHDOG_TIMEOUT_FLAG = st_r.tof;
  assign WDT_CLEAR = st_r.wdt_clr;
  assign WDT_RUN = st_r.wdt_run;
  assign CORE_STALL = st_r.stall;
  assign SYS_TICK_Q = tick_r;
endmodule
`default_nettype wire

// ### shared/lscm_defines.svh
// Constants for the low-speed clock and mode control block
`ifndef LSCM_DEFINES_SVH
`define LSCM_DEFINES_SVH
`define LSCM_OSC_HXT 2'h0
`define LSCM_OSC_ERC 2'h1
`define LSCM_OSC_HIGH_SPEED_INTERNAL_RC 2'h2
`define LSCM_OSC_HIGH_SPEED_INTERNAL_RC_LXT 2'h3
`define LSCM_WDTSRC_LOW_SPEED_INTERNAL_RC 2'h0
`define LSCM_WDTSRC_SYS 2'h1
`define LSCM_WDTSRC_LXT 2'h2
`define LSCM_LP_RESET 1'h0
`define LSCM_SEL_RESET 1'h0
`define LSCM_SYNC_STAGES 2
`endif

// ### shared/lscm_pkg.sv
// Types for the low-speed clock and mode control block
package lscm_pkg;
  typedef enum logic [1:0] {
    LSCM_NORMAL = 2'b00,
    LSCM_SLOW = 2'b01,
    LSCM_IDLE = 2'b10,
    LSCM_SLEEP = 2'b11
  } lscm_mode_type;

  typedef struct packed {
    logic lp;
    logic sel;
    lscm_mode_type mode;
    logic power_down_flag;
    logic tof;
    logic wdt_clr;
    logic wdt_run;
    logic high_speed_internal_rc_en;
    logic lxt_en;
    logic low_speed_internal_rc_en;
    logic stall;
  } lscm_state_type;

  typedef struct packed {
    logic [1:0] s_hi;
    logic [1:0] s_lo;
    logic en_hi;
    logic en_lo;
  } lscm_mux_type;
endpackage

// ### shared/lscm_mux_if.sv
// Interface between mode control and the clock switch
`timescale 1ns/10ps
`default_nettype none
interface lscm_mux_if;
  logic want_lo;
  logic gate;
  logic on_lo;
  logic on_hi;
  modport ctl (output want_lo, output gate, input on_lo, input on_hi);
  modport mux (input want_lo, input gate, output on_lo, output on_hi);
endinterface
`default_nettype wire

// ### src/lscm_clk_switch.sv
// Glitch-free switch between high and low speed clock enables
`timescale 1ns/10ps
`default_nettype none
module lscm_clk_switch (
  input wire logic clk, // Block clock
  input wire logic rst, // Synchronous reset
  input wire logic hi_tick, // High speed source tick
  input wire logic lo_tick, // Low speed source tick
  lscm_mux_if.mux ctl, // Selection from mode control
  output logic sys_tick // Gated system tick
);
  lscm_pkg::lscm_mux_type q_r;
  lscm_pkg::lscm_mux_type q_nxt;

  always_comb begin
    q_nxt = q_r;
    // Each side releases before the other may engage, so no short pulse
    q_nxt.s_hi = {q_r.s_hi[0], ~ctl.want_lo & ~q_r.en_lo};
    q_nxt.s_lo = {q_r.s_lo[0], ctl.want_lo & ~q_r.en_hi};
    if (hi_tick) begin
      q_nxt.en_hi = q_r.s_hi[1];
    end
    if (lo_tick) begin
      q_nxt.en_lo = q_r.s_lo[1];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sys_tick = ~ctl.gate & ((q_r.en_hi & hi_tick) | (q_r.en_lo & lo_tick));
  assign ctl.on_hi = q_r.en_hi;
  assign ctl.on_lo = q_r.en_lo;
endmodule
`default_nettype wire

// ### tb/lscm_monitor.sv
// Assertion checker bound to the mode control top
`timescale 1ns/10ps
`default_nettype none
module lscm_monitor (
  input wire logic REF_CLK, // Clock
  input wire logic RST, // Reset
  input wire logic [1:0] OSC_CFG, // Option
  input wire logic LP_WR, // Strobe
  input wire logic LP_WDATA, // Data
  input wire logic HALT, // Halt pulse
  input wire logic SLOW_OSC_LOW_POWER_BIT, // Bit
  input wire logic [1:0] MODE, // Mode
  input wire logic HIGH_SPEED_INTERNAL_RC_EN, // High RC
  input wire logic LOW_SPEED_CRYSTAL_OSC_EN, // Crystal
  input wire logic POWER_DOWN_FLAG, // Flag
  input wire logic WDT_CLEAR, // Clear
  input wire logic CORE_STALL // Stall
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_lp_after_reset: assert property ($past(RST) |-> !SLOW_OSC_LOW_POWER_BIT)
    else $error("low-power bit set after reset");
  a_lp_write_data: assert property (LP_WR |=> SLOW_OSC_LOW_POWER_BIT == $past(LP_WDATA))
    else $error("low-power bit not written");
  a_halt_mode_pick: assert property (HALT && !MODE[1] |=>
    MODE == (($past(OSC_CFG) == 2'h3) ? 2'h2 : 2'h3)) else $error("wrong halt mode");
  a_halt_sets_flags: assert property (HALT && !MODE[1] |=> POWER_DOWN_FLAG && WDT_CLEAR)
    else $error("halt flags wrong");
  a_high_rc_stop: assert property (MODE != 2'h0 |-> !HIGH_SPEED_INTERNAL_RC_EN)
    else $error("high RC runs outside Normal");
  a_high_rc_normal: assert property (MODE == 2'h0 |-> HIGH_SPEED_INTERNAL_RC_EN)
    else $error("high RC stopped in Normal");
  a_crystal_by_cfg: assert property (!RST |=>
    LOW_SPEED_CRYSTAL_OSC_EN == ($past(OSC_CFG) == 2'h3)) else $error("crystal enable wrong");
  a_stall_on_halt: assert property ($rose(CORE_STALL) |-> $past(HALT))
    else $error("stall without halt");
endmodule
bind lscm_ctrl lscm_monitor lscm_monitor_i (.REF_CLK, .RST, .OSC_CFG, .LP_WR, .LP_WDATA,
  .HALT, .SLOW_OSC_LOW_POWER_BIT, .MODE, .HIGH_SPEED_INTERNAL_RC_EN,
  .LOW_SPEED_CRYSTAL_OSC_EN, .POWER_DOWN_FLAG, .WDT_CLEAR, .CORE_STALL);
`default_nettype wire

// ### tb/lscm_xtal.sv
// Behavioural crystal giving one sampled tick every PERIOD clocks
`timescale 1ns/10ps
`default_nettype none
module lscm_xtal #(parameter int PERIOD = 7) (
  input wire logic clk, // Sampling clock
  input wire logic low_power, // Mode only changes current
  output logic lo_tick // Crystal tick
);
  int cnt = 0;
  initial lo_tick = 1'h0;
  always @(posedge clk) begin
    cnt <= (cnt + 1) % PERIOD;
    lo_tick <= (cnt == 0);
  end
endmodule
`default_nettype wire

// ### tb/low_speed_clock_mode_control_test.sv
// Random self-checking bench for the mode control block
`timescale 1ns/10ps
`default_nettype none
module low_speed_clock_mode_control_test;
  logic REF_CLK = 1'h0, RST = 1'h1, LOW_SPEED_INTERNAL_RC_OPT_EN = 1'h0, LP_WR = 1'h0, LP_WDATA = 1'h0;
  logic SEL_WR = 1'h0, SEL_WDATA = 1'h0, HALT = 1'h0, WAKE = 1'h0, WDT_TIMEOUT = 1'h0;
  logic CLR_WDT = 1'h0, HI_TICK = 1'h0, LO_TICK, SLOW_OSC_LOW_POWER_BIT;
  logic SYSTEM_CLOCK_SELECT_BIT, HIGH_SPEED_INTERNAL_RC_EN, LOW_SPEED_CRYSTAL_OSC_EN;
  logic LOW_SPEED_INTERNAL_RC_EN, POWER_DOWN_FLAG, WATCHDOG_TIMEOUT_FLAG, WDT_RUN;
  logic [1:0] OSC_CFG = 2'h0, WDT_SRC = 2'h0, MODE;
  logic m_lp = 1'h0, m_sel = 1'h0, m_pdf = 1'h0, m_to = 1'h0, m_clr = 1'h0;
  logic WDT_CLEAR, CORE_STALL, SYS_TICK_Q;
  int miscompares = 0, n_tests = 0, seed = 15, ev, mode = 0, pmode = 0;
  lscm_ctrl lscm_ctrl_i (.REF_CLK, .RST, .OSC_CFG, .WDT_SRC, .LOW_SPEED_INTERNAL_RC_OPT_EN, .LP_WR,
    .LP_WDATA, .SEL_WR, .SEL_WDATA, .HALT, .WAKE, .WDT_TIMEOUT, .CLR_WDT, .HI_TICK,
    .LO_TICK, .SLOW_OSC_LOW_POWER_BIT, .SYSTEM_CLOCK_SELECT_BIT, .MODE,
    .HIGH_SPEED_INTERNAL_RC_EN, .LOW_SPEED_CRYSTAL_OSC_EN, .LOW_SPEED_INTERNAL_RC_EN,
    .POWER_DOWN_FLAG, .WATCHDOG_TIMEOUT_FLAG, .WDT_CLEAR, .WDT_RUN, .CORE_STALL,
    .SYS_TICK_Q);
  lscm_xtal lscm_xtal_i (.clk(REF_CLK), .low_power(SLOW_OSC_LOW_POWER_BIT), .lo_tick(LO_TICK));
  initial forever #2 REF_CLK = ~REF_CLK;
  task automatic chk(input string what, input logic [1:0] seen, input logic [1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    results();
  end
  // ****************
  // Random events, at most one per cycle
  // ****************
  initial begin
    repeat (20) @(negedge REF_CLK);
    RST = 1'h0;
    for (int i = 0; i < 8000; i++) begin
      // Every oscillator configuration in turn
      OSC_CFG = 2'(i / 2000);
      // Second reset in mid-run
      RST = (i == 4000);
      ev = $unsigned($random(seed)) % 8;
      {LP_WR, SEL_WR, HALT, WAKE, WDT_TIMEOUT, CLR_WDT} = 6'h0;
      LP_WDATA = 1'($random(seed));
      SEL_WDATA = 1'($random(seed));
      LOW_SPEED_INTERNAL_RC_OPT_EN = 1'($random(seed));
      HI_TICK = 1'($random(seed));
      WDT_SRC = 2'($unsigned($random(seed)) % 3);
      case (ev)
        1: LP_WR = 1'h1;
        2: SEL_WR = 1'h1;
        3: HALT = 1'h1;
        4: WAKE = 1'h1;
        5: WDT_TIMEOUT = 1'h1;
        6: CLR_WDT = 1'h1;
        default: ;
      endcase
      if (RST) begin
        {LP_WR, SEL_WR, HALT, WAKE, WDT_TIMEOUT, CLR_WDT} = 6'h0;
        LOW_SPEED_INTERNAL_RC_OPT_EN = 1'h0;
      end
      pmode = mode;
      m_clr = CLR_WDT || (HALT && mode < 2);
      if (LP_WR) m_lp = LP_WDATA;
      if (SEL_WR) m_sel = SEL_WDATA;
      if (HALT && mode < 2) begin
        mode = (OSC_CFG == 2'h3) ? 2 : 3;
        m_pdf = 1'h1;
        m_to = 1'h0;
      end else if (mode < 2 || WAKE || WDT_TIMEOUT) mode = (OSC_CFG == 2'h3 && m_sel) ? 1 : 0;
      if (WDT_TIMEOUT) m_to = 1'h1;
      if (CLR_WDT) m_pdf = 1'h0;
      if (RST) begin
        {m_lp, m_sel, m_pdf, m_to, m_clr} = 5'h00;
        mode = 0;
      end
      @(negedge REF_CLK);
      chk("lp", {1'h0, SLOW_OSC_LOW_POWER_BIT}, {1'h0, m_lp});
      chk("mode", MODE, 2'(mode));
      chk("flags", {POWER_DOWN_FLAG, WATCHDOG_TIMEOUT_FLAG}, {m_pdf, m_to});
      chk("osc", {HIGH_SPEED_INTERNAL_RC_EN, LOW_SPEED_CRYSTAL_OSC_EN}, {mode == 0, OSC_CFG == 2'h3});
      chk("wdt", {WDT_RUN, LOW_SPEED_INTERNAL_RC_EN}, {mode < 2 || WDT_SRC != 2'h1, LOW_SPEED_INTERNAL_RC_OPT_EN});
      chk("sel", {1'h0, SYSTEM_CLOCK_SELECT_BIT}, {1'h0, m_sel});
      chk("stall", {CORE_STALL, WDT_CLEAR}, {mode > 1, m_clr});
      chk("tick", {1'h0, SYS_TICK_Q & (pmode > 1)}, 2'h0);
    end
    results();
  end
endmodule
`default_nettype wire
